/* File: design/psbpd_core.sv */
// Operation
// - Power-down pin low idles the memory until it returns high.
// - With reset-select one, retention field picks sleep or 16/32/64 Mbit partial.
// - Sleep is default, lowest power, loses all data on entry.
// - With reset-select zero, power-down low returns to asynchronous standby.
// - A configuration set precedes bursts and supplies latency and length.
// - Latch strobe honoured only with chip select low; high strobe ignores address.
// - Wait low means next data invalid; rises one clock before first data.
// - During enable-driven suspends wait holds its previous high level.
// - In burst write, wait rises after write enable and chip select low.
// - No refresh stalls; wait stays high until burst ends or terminates.
// - In asynchronous mode wait is not driven.
// - Read latency counts latch to data; write latency is one less.
// - Address captured on first edge with strobe and chip select low.
// - Bursts step by one and wrap inside an aligned 8 to 128 boundary.
// - Burst ends by itself after the configured number of words.
// - Pulse mode: write seen at an edge; level mode: low level writes.
// - Output enable high freezes the counter and floats data; low restarts.
// - After read suspend the first word repeats the last address output.
// - Latency field codes 010, 011, 100 give 4, 5, 6 clocks.
// - Length codes 010 to 110 give 8 to 128 words; mode bit zero is synchronous.
//
// Memory-side burst and power-down logic of a 16-bit pseudo-static memory.
// Assumes all pins are synchronous to MCLK; the array is a small model of the low words.
`timescale 1ns/1ps
module psbpd_core
  import psbpd_pkg::*;
(
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST,
  // Memory control pins.
  input wire logic POWER_DOWN_CONTROL,
  input wire logic CHIP_SELECT_N,
  input wire logic ADDRESS_LATCH_STROBE_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [ADDR_W-1:0] ADDR,
  // Data bus, split into its three signals.
  input wire logic [DATA_W-1:0] DQ_IN,
  output logic [DATA_W-1:0] DQ_OUT,
  output logic DQ_OE_N,
  // Wait-state pin, split into its two signals.
  output logic WAIT_OUT,
  output logic WAIT_OE_N,
  // Configuration keys as written by the set sequence, with its load strobe.
  input wire logic CONFIG_LOAD,
  input wire logic [DATA_W-1:0] CONFIG_KEY1,
  input wire logic [DATA_W-1:0] CONFIG_KEY2,
  // Status.
  output logic POWERED_DOWN,
  output logic DATA_RETAINED,
  output logic BURST_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////////
  // Field decode.

  // Burst length code to word count minus one, used as wrap mask.
  function automatic logic [ADDR_W-1:0] len_mask(input logic [2:0] code);
    case (code)
      BL_8: len_mask = 23'h000007;
      BL_16: len_mask = 23'h00000f;
      BL_32: len_mask = 23'h00001f;
      BL_64: len_mask = 23'h00003f;
      default: len_mask = 23'h00007f;
    endcase
  endfunction : len_mask

  // Latency code to clock count; prohibited codes fall back to the shortest.
  function automatic logic [7:0] lat_of(input logic [2:0] code);
    case (code)
      RLF_5: lat_of = LAT_5;
      RLF_6: lat_of = LAT_6;
      default: lat_of = LAT_4;
    endcase
  endfunction : lat_of

  logic [DATA_W-1:0] key1_reg;
  logic [DATA_W-1:0] key2_reg;
  logic configured_reg;
  wire [2:0] burst_length_field = key1_reg[BL_LSB +: 3];
  wire [1:0] retention_size = key1_reg[RS_LSB +: 2];
  wire [2:0] read_latency_field = key2_reg[RLF_LSB +: 3];
  wire async_reset_select = key2_reg[ARS_BIT];
  wire write_control_select = key2_reg[WCS_BIT];
  // Synchronous only after a set that cleared the mode bit.
  wire sync_mode = configured_reg && !key1_reg[MODE_BIT];
  wire [ADDR_W-1:0] wrap_mask = len_mask(burst_length_field);
  wire [7:0] rd_lat = lat_of(read_latency_field);
  wire [7:0] wr_lat = 8'(rd_lat - ONE8);
  wire [7:0] words = 8'(wrap_mask[7:0] + ONE8);

  // Retention limit for the selected partial mode.
  wire [ADDR_W-1:0] ret_top = (retention_size == RS_16M) ? RET_TOP_16M :
                              (retention_size == RS_32M) ? RET_TOP_32M : RET_TOP_64M;
  wire keeps_data = async_reset_select && (retention_size != RS_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine.

  psbpd_state_e state_reg;
  psbpd_state_e state_next;
  logic [7:0] lat_cnt_reg;
  logic [7:0] word_cnt_reg;
  logic is_write_reg;
  logic wait_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic dq_oe_n_reg;
  logic resume_reg;
  logic [DATA_W-1:0] mem [0:(1 << MEM_W) - 1];
  wire [ADDR_W-1:0] cur_addr;

  // Latch is valid only with chip select low.
  wire latch_hit = !ADDRESS_LATCH_STROBE_N && !CHIP_SELECT_N;
  wire start = (state_reg == PS_IDLE) && sync_mode && latch_hit && POWER_DOWN_CONTROL;
  wire lat_done = (lat_cnt_reg == ONE8);
  // Pulse mode needs write enable low at the latch edge; level mode accepts it at any edge until latency ends.
  wire wr_at_latch = !WRITE_ENABLE_N;
  wire in_burst = (state_reg == PS_READ) || (state_reg == PS_WRITE);
  // Read suspend by output enable; write suspend only in level mode.
  wire rd_susp = (state_reg == PS_READ) && OUTPUT_ENABLE_N;
  wire wr_susp = (state_reg == PS_WRITE) && WRITE_ENABLE_N && write_control_select;
  // First clock after a read suspend re-drives the held word instead of stepping.
  wire rd_repeat = (state_reg == PS_READ) && !OUTPUT_ENABLE_N && resume_reg;
  wire step = in_burst && !rd_susp && !wr_susp && !rd_repeat;
  wire last_word = step && (word_cnt_reg == ONE8);
  wire first_is_write = is_write_reg || (write_control_select && !WRITE_ENABLE_N);
  // Both directions leave latency on one edge: the write word is taken on the next
  // edge, and the read word is registered there so that it is sampled a clock later.
  wire [7:0] load_lat = 8'(wr_lat - ONE8);

  // Next state: power-down wins, chip select high terminates, length ends.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PS_IDLE: if (start) state_next = PS_LAT;
      PS_LAT: if (lat_done) state_next = first_is_write ? PS_WRITE : PS_READ;
      PS_READ: if (last_word) state_next = PS_IDLE;
      PS_WRITE: if (last_word) state_next = PS_IDLE;
      PS_PDOWN: state_next = PS_IDLE;
      default: state_next = PS_IDLE;
    endcase
    if (!POWER_DOWN_CONTROL) begin
      state_next = PS_PDOWN;
    end else if (CHIP_SELECT_N && state_reg != PS_PDOWN) begin
      state_next = PS_IDLE;
    end
  end

  psbpd_counter u_counter (
    .clk(MCLK),
    .rst(RST),
    .load(start),
    .advance(step),
    .start_addr(ADDR),
    .wrap_mask(wrap_mask),
    .addr(cur_addr)
  );

  // State and counters.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_reg <= PS_IDLE;
      lat_cnt_reg <= ZERO8;
      word_cnt_reg <= ZERO8;
      is_write_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        is_write_reg <= wr_at_latch;
        lat_cnt_reg <= load_lat;
        word_cnt_reg <= words;
      end else if (state_reg == PS_LAT) begin
        lat_cnt_reg <= 8'(lat_cnt_reg - ONE8);
        if (!write_control_select && !is_write_reg && lat_cnt_reg == load_lat) begin
          is_write_reg <= 1'b0;
        end else if (write_control_select && !WRITE_ENABLE_N) begin
          is_write_reg <= 1'b1;
        end
      end else if (step) begin
        word_cnt_reg <= 8'(word_cnt_reg - ONE8);
      end
    end
  end

  // Configuration store; power-down with reset-select zero restores asynchronous mode.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      key1_reg <= KEY1_RST;
      key2_reg <= KEY2_RST;
      configured_reg <= 1'b0;
    end else if (CONFIG_LOAD) begin
      key1_reg <= CONFIG_KEY1;
      key2_reg <= CONFIG_KEY2;
      configured_reg <= 1'b1;
    end else if (!POWER_DOWN_CONTROL && !async_reset_select) begin
      configured_reg <= 1'b0;
    end
  end

  // Array: writes on write steps; power-down clears words outside retention.
  always_ff @(posedge MCLK) begin
    for (int i = 0; i < (1 << MEM_W); i++) begin
      if (state_reg != PS_PDOWN && !POWER_DOWN_CONTROL &&
          (!keeps_data || ADDR_W'(i) > ret_top)) begin
        mem[i] <= '0;
      end
    end
    if (state_reg == PS_WRITE && step) begin
      mem[cur_addr[MEM_W-1:0]] <= DQ_IN;
    end
  end

  // Wait rises one clock before first read word, and with the write; holds through suspends.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wait_reg <= 1'b0;
      dq_out_reg <= '0;
      dq_oe_n_reg <= 1'b1;
      resume_reg <= 1'b0;
    end else begin
      if (state_next == PS_IDLE || state_next == PS_PDOWN) begin
        wait_reg <= 1'b0;
      end else if (state_reg == PS_LAT && lat_done) begin
        wait_reg <= 1'b1;
      end
      // Data drives while output enable is low; suspends float the bus.
      dq_oe_n_reg <= !(state_reg == PS_READ && !OUTPUT_ENABLE_N);
      resume_reg <= rd_susp;
      // The held word is not reloaded on the resume clock, so it repeats.
      if (state_reg == PS_READ && step) begin
        dq_out_reg <= mem[cur_addr[MEM_W-1:0]];
      end
    end
  end

  // Outputs straight from flip-flops; wait floats outside synchronous mode.
  assign WAIT_OUT = wait_reg;
  assign DQ_OUT = dq_out_reg;
  assign DQ_OE_N = dq_oe_n_reg;
  logic wait_oe_n_reg;
  logic pd_reg;
  logic ret_reg;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wait_oe_n_reg <= 1'b1;
      pd_reg <= 1'b0;
      ret_reg <= 1'b0;
    end else begin
      wait_oe_n_reg <= !(sync_mode && !CHIP_SELECT_N);
      pd_reg <= !POWER_DOWN_CONTROL;
      ret_reg <= keeps_data;
    end
  end
  assign WAIT_OE_N = wait_oe_n_reg;
  assign POWERED_DOWN = pd_reg;
  assign DATA_RETAINED = ret_reg;
  assign BURST_ACTIVE = wait_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_pd_idle;
    @(posedge MCLK) disable iff (RST)
      !POWER_DOWN_CONTROL |=> (state_reg == PS_PDOWN) && !wait_reg;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("Power down not entered.");

  property p_async_float;
    @(posedge MCLK) disable iff (RST)
      !sync_mode |=> WAIT_OE_N;
  endproperty
  a_async_float: assert property (p_async_float) else $error("Wait driven in async.");

  property p_wait_holds;
    @(posedge MCLK) disable iff (RST)
      (wait_reg && in_burst && (rd_susp || wr_susp) && CHIP_SELECT_N == 1'b0
       && POWER_DOWN_CONTROL && !last_word) |=> wait_reg;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("Wait dropped in suspend.");

  property p_no_start_cs_high;
    @(posedge MCLK) disable iff (RST)
      CHIP_SELECT_N |-> !start;
  endproperty
  a_no_start_cs_high: assert property (p_no_start_cs_high) else $error("Latch without select.");

  property p_reset_select;
    @(posedge MCLK) disable iff (RST)
      (!POWER_DOWN_CONTROL && !async_reset_select && !CONFIG_LOAD) |=> !sync_mode;
  endproperty
  a_reset_select: assert property (p_reset_select) else $error("Mode not reset.");

  property p_read_latency;
    @(posedge MCLK) disable iff (RST)
      (start && WRITE_ENABLE_N && read_latency_field == RLF_4 && !write_control_select
       && OUTPUT_ENABLE_N == 1'b0)
      ##1 (POWER_DOWN_CONTROL && !CHIP_SELECT_N && !OUTPUT_ENABLE_N)[*4]
      |-> (state_reg == PS_READ) && !DQ_OE_N && $past(DQ_OE_N);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("Read latency wrong.");

  property p_wait_before_data;
    @(posedge MCLK) disable iff (RST)
      (state_reg == PS_READ && $past(state_reg) == PS_LAT) |-> wait_reg && !$past(wait_reg);
  endproperty
  a_wait_before_data: assert property (p_wait_before_data) else $error("Wait late.");

  property p_no_midburst_drop;
    @(posedge MCLK) disable iff (RST)
      (wait_reg && step && !last_word && !CHIP_SELECT_N && POWER_DOWN_CONTROL) |=> wait_reg;
  endproperty
  a_no_midburst_drop: assert property (p_no_midburst_drop) else $error("Wait dropped.");

  property p_burst_ends;
    @(posedge MCLK) disable iff (RST)
      last_word |=> (state_reg != PS_READ && state_reg != PS_WRITE);
  endproperty
  a_burst_ends: assert property (p_burst_ends) else $error("Burst overran.");
endmodule : psbpd_core

/* File: design/psbpd_pkg.sv */
// Package for the pseudo-static memory burst and power-down block.
// Assumes a single 100 MHz clock domain; shared by the core and its burst counter.
package psbpd_pkg;
  // Widths.
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int MEM_W = 8;
  // Configuration key 1 fields.
  localparam int RS_LSB = 0;
  localparam int BL_LSB = 2;
  localparam int MODE_BIT = 5;
  // Configuration key 2 fields.
  localparam int RLF_LSB = 0;
  localparam int ARS_BIT = 6;
  localparam int WCS_BIT = 7;
  // Field codes.
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [2:0] BL_32 = 3'h4;
  localparam logic [2:0] BL_64 = 3'h5;
  localparam logic [2:0] BL_128 = 3'h6;
  localparam logic [2:0] RLF_4 = 3'h2;
  localparam logic [2:0] RLF_5 = 3'h3;
  localparam logic [2:0] RLF_6 = 3'h4;
  localparam logic [7:0] LAT_4 = 8'h04;
  localparam logic [7:0] LAT_5 = 8'h05;
  localparam logic [7:0] LAT_6 = 8'h06;
  localparam logic [1:0] RS_32M = 2'h0;
  localparam logic [1:0] RS_16M = 2'h1;
  localparam logic [1:0] RS_64M = 2'h2;
  localparam logic [1:0] RS_SLEEP = 2'h3;
  // Retention top addresses (word-address limit of retained region).
  localparam logic [ADDR_W-1:0] RET_TOP_16M = 23'h00ffff;
  localparam logic [ADDR_W-1:0] RET_TOP_32M = 23'h01ffff;
  localparam logic [ADDR_W-1:0] RET_TOP_64M = 23'h03ffff;
  // Reset values of the configuration: asynchronous mode, sleep, remain mode.
  localparam logic [15:0] KEY1_RST = 16'hffff;
  localparam logic [15:0] KEY2_RST = 16'hffff;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Burst engine states.
  typedef enum logic [4:0] {
    PS_IDLE = 5'b00001,
    PS_LAT = 5'b00010,
    PS_READ = 5'b00100,
    PS_WRITE = 5'b01000,
    PS_PDOWN = 5'b10000
  } psbpd_state_e;
endpackage : psbpd_pkg

/* File: design/psbpd_counter.sv */
// Wrapping burst address counter for the pseudo-static memory block.
// Assumes the core presents a load strobe and an advance strobe, never both useful at once.
`timescale 1ns/1ps
module psbpd_counter
  import psbpd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic load,
  input wire logic advance,
  input wire logic [ADDR_W-1:0] start_addr,
  input wire logic [ADDR_W-1:0] wrap_mask,
  // Result.
  output logic [ADDR_W-1:0] addr
);

  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  wire [ADDR_W-1:0] inc_addr = ADDR_W'(addr_reg + 23'h000001);

  // Low bits step and wrap inside the aligned boundary; high bits never move.
  assign addr_next = load ? start_addr :
                     advance ? ((addr_reg & ~wrap_mask) | (inc_addr & wrap_mask)) : addr_reg;
  assign addr = addr_reg;

  // Address register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  property p_wrap_keeps_high;
    @(posedge clk) disable iff (rst)
      (advance && !load) |=> ((addr_reg & ~wrap_mask) == ($past(addr_reg) & ~$past(wrap_mask)));
  endproperty
  a_wrap_keeps_high: assert property (p_wrap_keeps_high) else $error("Burst left boundary.");
endmodule : psbpd_counter

/* File: bench/psbpd_ctl.sv */
// Controller-side model that runs one burst on the memory pins per call.
// Assumes one clock; every pin changes by non-blocking assignment just after a rising edge.
`timescale 1ns/1ps
module psbpd_ctl
  import psbpd_pkg::*;
(
  // Clock.
  input wire logic mclk,
  // Pins driven toward the memory.
  output logic ce_n,
  output logic adv_n,
  output logic we_n,
  output logic oe_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq,
  // Pins seen from the memory.
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic wait_out,
  input wire logic wait_oe_n
);
  logic [DATA_W-1:0] rdq [$];
  int first_seen;
  bit saw_float;
  bit timed_out;
  bit wait_driven;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle pin levels before the first burst.
  initial begin
    ce_n = 1'b1;
    adv_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    addr = '0;
    dq = '0;
  end

  // One burst: wr selects write, wl is write enable at the latch edge, lim bounds the wait.
  // The edge after the strobe edge is cycle 1; write data carries its cycle number.
  task automatic burst(input bit wr, input bit wl, input logic [ADDR_W-1:0] a, input int lim,
                       input int susp, input logic [7:0] hi);
    int cyc;
    int scnt;
    bit sdone;
    bit wprev;
    rdq.delete();
    first_seen = 0;
    saw_float = 0;
    timed_out = 1;
    wait_driven = 0;
    wprev = 0;
    scnt = 0;
    sdone = 0;
    ce_n <= 1'b0;
    adv_n <= 1'b0;
    addr <= a;
    we_n <= wl;
    oe_n <= wr;
    dq <= {hi, 8'h00};
    @(posedge mclk);
    // The strobe goes high for good; the address lines then carry garbage.
    adv_n <= 1'b1;
    addr <= ~a;
    we_n <= wr ? !wl : 1'b1;
    for (cyc = 1; cyc < lim; cyc++) begin
      // A released data line flips every cycle so stale values never pass.
      dq <= wr ? {hi, cyc[7:0]} : ~dq;
      // Never suspend before the first word has been taken.
      if (!wr && susp > 0 && rdq.size() == susp && !sdone) begin
        scnt = 3;
        sdone = 1;
      end
      oe_n <= wr || (scnt > 0);
      if (scnt > 0) scnt--;
      @(posedge mclk);
      if (wait_oe_n === 1'b0) wait_driven = 1;
      if (wait_out === 1'b1 && rdq.size() > 0 && dq_oe_n === 1'b1) saw_float = 1;
      if (!wr && wprev && dq_oe_n === 1'b0) begin
        rdq.push_back(dq_out);
        if (first_seen == 0) first_seen = cyc;
      end
      // Wait low after a high cycle: the word just taken was the last one.
      if (wprev && wait_out !== 1'b1) begin
        timed_out = 0;
        break;
      end
      wprev = (wait_out === 1'b1);
    end
    ce_n <= 1'b1;
    we_n <= 1'b1;
    oe_n <= 1'b1;
    @(posedge mclk);
  endtask : burst

  // Asynchronous access with the strobe simply tied low for n cycles.
  task automatic strobe_low(input int n);
    wait_driven = 0;
    ce_n <= 1'b0;
    adv_n <= 1'b0;
    repeat (n) begin
      @(posedge mclk);
      if (wait_oe_n === 1'b0 || wait_out === 1'b1) wait_driven = 1;
    end
    ce_n <= 1'b1;
    adv_n <= 1'b1;
    @(posedge mclk);
  endtask : strobe_low
endmodule : psbpd_ctl

/* File: bench/tb.sv */
// Self-checking bench of the burst and power-down core against a word-array model.
// Assumes the controller model drives the pins and the bench drives power-down and config.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin \
  compares++; \
  if ((sn) !== (ex)) begin \
    failures++; \
    $display("Error %s expected %0h seen %0h", nm, ex, sn); \
  end \
end
module tb
  import psbpd_pkg::*;
;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic pd_ctl = 1'b1;
  logic cfg_load = 1'b0;
  logic [DATA_W-1:0] key1 = KEY1_RST;
  logic [DATA_W-1:0] key2 = KEY2_RST;
  wire logic ce_n, adv_n, we_n, oe_n, dq_oe_n, wait_out, wait_oe_n, pdn, ret, bact;
  wire logic [ADDR_W-1:0] addr;
  wire logic [DATA_W-1:0] dq_in, dq_out;
  logic [DATA_W-1:0] mem [256];
  logic [1:0] rs_tab [4] = '{RS_16M, RS_32M, RS_64M, RS_SLEEP};
  int failures = 0;
  int compares = 0;
  int seed = 32'h6838;

  // The clock runs without a break, as bursts need it outside power down.
  always #5 MCLK = ~MCLK;

  psbpd_core psbpd_core_i (.MCLK(MCLK), .RST(RST), .POWER_DOWN_CONTROL(pd_ctl),
    .CHIP_SELECT_N(ce_n), .ADDRESS_LATCH_STROBE_N(adv_n), .WRITE_ENABLE_N(we_n),
    .OUTPUT_ENABLE_N(oe_n), .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n),
    .WAIT_OUT(wait_out), .WAIT_OE_N(wait_oe_n), .CONFIG_LOAD(cfg_load), .CONFIG_KEY1(key1),
    .CONFIG_KEY2(key2), .POWERED_DOWN(pdn), .DATA_RETAINED(ret), .BURST_ACTIVE(bact));
  psbpd_ctl psbpd_ctl_i (.mclk(MCLK), .ce_n(ce_n), .adv_n(adv_n), .we_n(we_n), .oe_n(oe_n),
    .addr(addr), .dq(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wait_out(wait_out),
    .wait_oe_n(wait_oe_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Loads both keys in one strobe, synchronous mode always, unused bits at one except bit 4 of key 2.
  task automatic cfg(input logic [2:0] bl, input logic [2:0] rl, input logic [1:0] rs,
                     input bit ra, input bit wc);
    @(posedge MCLK);
    key1 <= {8'hff, 2'b11, 1'b0, bl, rs};
    key2 <= {8'hff, wc, ra, 3'b101, rl};
    cfg_load <= 1'b1;
    @(posedge MCLK);
    cfg_load <= 1'b0;
  endtask : cfg

  // Power-down pulse of four cycles with status checks on both sides.
  task automatic pdown(input bit kept);
    pd_ctl <= 1'b0;
    repeat (4) @(posedge MCLK);
    `CHK("powered_down", 1'b1, pdn)
    `CHK("data_retained", kept, ret)
    pd_ctl <= 1'b1;
    repeat (4) @(posedge MCLK);
    `CHK("powered_down", 1'b0, pdn)
  endtask : pdown

  // Address of word k of a burst wrapping inside its aligned block.
  function automatic logic [7:0] wa(input logic [ADDR_W-1:0] a, input int len, input int k);
    return 8'((a & ~(len - 1)) | ((a + k) & (len - 1)));
  endfunction : wa

  // A write burst lands word k on the edge write latency plus k after the latch.
  task automatic wr_blk(input logic [ADDR_W-1:0] a, input int len, input int rl, input bit pls);
    logic [7:0] hi;
    hi = 8'($random(seed));
    psbpd_ctl_i.burst(1'b1, !pls, a, rl + len + 20, 0, hi);
    `CHK("write_done", 1'b0, psbpd_ctl_i.timed_out)
    for (int k = 0; k < len; k++) mem[wa(a, len, k)] = {hi, 8'(rl - 1 + k)};
  endtask : wr_blk

  // A read burst; repeated words of a suspend are folded before comparing.
  task automatic rd_blk(input logic [ADDR_W-1:0] a, input int len, input int rl, input int sus);
    logic [DATA_W-1:0] w [$];
    psbpd_ctl_i.burst(1'b0, 1'b1, a, rl + len + 20, sus, 8'h00);
    `CHK("read_done", 1'b0, psbpd_ctl_i.timed_out)
    `CHK("first_data_cycle", rl, psbpd_ctl_i.first_seen)
    foreach (psbpd_ctl_i.rdq[j]) begin
      if (j == 0 || psbpd_ctl_i.rdq[j] !== psbpd_ctl_i.rdq[j - 1]) w.push_back(psbpd_ctl_i.rdq[j]);
    end
    `CHK("word_count", len, w.size())
    if (sus == 0) `CHK("raw_count", len, psbpd_ctl_i.rdq.size())
    if (sus > 0) `CHK("suspend_float", 1'b1, psbpd_ctl_i.saw_float)
    if (sus > 0) `CHK("resume_repeat", len + 1, psbpd_ctl_i.rdq.size())
    for (int k = 0; k < len && k < w.size(); k++) begin
      `CHK("read_word", mem[wa(a, len, k)], w[k])
    end
  endtask : rd_blk

  // A strobe that must be refused: no wait handshake and the wait pin never driven.
  task automatic refused();
    psbpd_ctl_i.burst(1'b0, 1'b1, 23'h000010, 30, 0, 8'h00);
    `CHK("async_refused", 1'b1, psbpd_ctl_i.timed_out)
    `CHK("wait_undriven", 1'b0, psbpd_ctl_i.wait_driven)
    psbpd_ctl_i.strobe_low(8);
    `CHK("strobe_low_ignored", 1'b0, psbpd_ctl_i.wait_driven)
  endtask : refused

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [ADDR_W-1:0] a;
    int len;
    int rl;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    `CHK("dq_oe_n", 1'b1, dq_oe_n) // reset
    `CHK("wait_oe_n", 1'b1, wait_oe_n) // reset
    `CHK("burst_active", 1'b0, bact) // reset
    refused();
    // Every length and latency code, pulse and level write control in turn.
    for (int i = 0; i < 5; i++) begin
      len = 8 << i;
      rl = 4 + i % 3;
      a = ADDR_W'($random(seed)) & 23'h0000ff;
      cfg(BL_8 + 3'(i), RLF_4 + 3'(i % 3), RS_16M, 1'b1, i % 2 == 1);
      wr_blk(a, len, rl, i % 2 == 0);
      a = (a & ~ADDR_W'(len - 1)) | (ADDR_W'($random(seed)) & ADDR_W'(len - 1));
      rd_blk(a, len, rl, (i % 3 == 0) ? 0 : 2);
    end
    // Retention modes; the first partial one (16 Mbit) must keep the low block intact.
    for (int i = 0; i < 4; i++) begin
      cfg(BL_128, RLF_5, rs_tab[i], 1'b1, 1'b1);
      pdown(i < 3);
      if (i == 0) rd_blk(a, 128, 5, 0);
    end
    // With reset-select zero a power-down pulse falls back to asynchronous mode.
    cfg(BL_8, RLF_4, RS_16M, 1'b0, 1'b1);
    pd_ctl <= 1'b0;
    repeat (4) @(posedge MCLK);
    pd_ctl <= 1'b1;
    repeat (4) @(posedge MCLK);
    refused();
    close_out();
  end
endmodule : tb
